// [core/pmt_ctrl.sv]
// pmt_ctrl.sv: pm control registers behind index/data port, with minute time-out timer
// assumes host strobes synchronous to i_ref_clk; strap, irq and status inputs are asynchronous
`timescale 1ns/100ps
`include "pmt_regs.svh"
module pmt_ctrl #(
  parameter int unsigned CLK_HZ = 40000000,
  parameter int unsigned MINUTE_CYCLES = CLK_HZ * `PMT_MINUTE_S
) (
  input wire logic i_ref_clk, // 40 MHz clock
  input wire logic i_rst, // async reset, high
  input wire logic i_sw_rst, // software reset pulse
  input wire logic i_pm_activate, // pm device activation pulse
  input wire logic i_addr, // 0 index port, 1 data port
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data, registered
  input wire logic i_clk_strap_pin, // clock strap
  input wire logic i_mul_stable, // multiplier output toggling
  input wire logic i_uart2_busy, // uart2 busy
  input wire logic i_uart1_busy, // uart1 busy
  input wire pmt_pkg::pmt_func_s i_cfg_hiz, // functions' own config bit 0
  input wire pmt_pkg::pmt_func_s i_cfg_clk, // functions' own config bit 1
  input wire logic [3:0] i_irq_active, // active irqs: uart2, uart1, mouse, kbd ctrl
  output pmt_pkg::pmt_func_s o_hiz, // per-function high-z
  output logic o_par_clk_en, // parallel port clock run
  output logic o_uart2_clk_en, // uart2 clock run
  output logic o_uart1_clk_en, // uart1 clock run
  output logic [1:0] o_clk_src, // internal clock source
  output logic o_mul_en, // multiplier enable
  output logic o_gpio_en, // gpio ports enable
  output logic o_pm_timer_en, // pm timer registers accessible
  output logic o_pm_active, // pm function active
  output logic o_timeout_out_n // time-out output, active low
);
  initial
  begin
    if (MINUTE_CYCLES < 2)
    begin
      $error("MINUTE_CYCLES too small");
    end
    if (CLK_HZ == 0)
    begin
      $error("CLK_HZ must be non-zero");
    end
  end
  localparam int unsigned PW = $clog2(MINUTE_CYCLES);

  logic [1:0] strap_s_q;
  logic [1:0] mul_s_q;
  logic [1:0] b2_s_q;
  logic [1:0] b1_s_q;
  logic [3:0] irq_s1_q;
  logic [3:0] irq_s2_q;
  logic [4:0] idx_q;
  logic [7:0] fen2_q;
  logic [7:0] hiz_q;
  logic [7:0] gate_q;
  logic [7:0] period_q;
  logic [7:0] trig_q;
  logic [7:0] rdata_q;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [2:0] src_q;
  logic [1:0] strap_wait_q;
  logic out_n_q;
  logic out_n_d;
  logic pm_act_q;
  logic [PW-1:0] pre_q;
  logic [PW-1:0] pre_d;
  pmt_pkg::pmt_state_e st_q;
  pmt_pkg::pmt_state_e st_d;

  // status synchronisers
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      strap_s_q <= 2'h0;
      mul_s_q <= 2'h0;
      b2_s_q <= 2'h0;
      b1_s_q <= 2'h0;
    end
    else
    begin
      strap_s_q <= {strap_s_q[0], i_clk_strap_pin};
      mul_s_q <= {mul_s_q[0], i_mul_stable};
      b2_s_q <= {b2_s_q[0], i_uart2_busy};
      b1_s_q <= {b1_s_q[0], i_uart1_busy};
    end
  end

  // irq synchroniser, first stage read only by the second
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      irq_s1_q <= 4'h0;
      irq_s2_q <= 4'h0;
    end
    else
    begin
      irq_s1_q <= i_irq_active;
      irq_s2_q <= irq_s1_q;
    end
  end

  // index decode
  wire wr_idx = i_wr & ~i_addr;
  wire wr_dat = i_wr & i_addr;
  wire sel_fen2 = (idx_q == `PMT_IDX_FUNC_EN2);
  wire sel_hiz = (idx_q == `PMT_IDX_HIZ);
  wire sel_clksrc = (idx_q == `PMT_IDX_CLKSRC);
  wire sel_gate = (idx_q == `PMT_IDX_GATE);
  wire sel_period = (idx_q == `PMT_IDX_PERIOD);
  wire sel_trig = (idx_q == `PMT_IDX_TRIG);
  wire wr_fen2 = wr_dat & sel_fen2;
  wire wr_hiz = wr_dat & sel_hiz;
  wire wr_clksrc = wr_dat & sel_clksrc;
  wire wr_gate = wr_dat & sel_gate;
  wire wr_period = wr_dat & sel_period;
  wire wr_trig = wr_dat & sel_trig;
  // strap read once the synchroniser holds a sampled pin value
  wire strap_load = (strap_wait_q == `PMT_STRAP_SETTLE);
  // pm activation and software reset both reinit the timer group
  wire tmr_init = i_sw_rst | i_pm_activate;
  wire [3:0] trig_hit = irq_s2_q & trig_q[3:0];
  wire reload = (|trig_hit) & (period_q != 8'h00) & (st_q == pmt_pkg::PMT_ST_RUN);
  wire tick = (pre_q == PW'(MINUTE_CYCLES - 1));

  function automatic logic [7:0] wmerge(input logic [7:0] old, input logic [7:0] nw, input logic [7:0] m);
    wmerge = (old & ~m) | (nw & m);
  endfunction

  // index register
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      idx_q <= `PMT_RST_IDX;
    end
    else if (wr_idx)
    begin
      idx_q <= i_wdata[4:0];
    end
  end

  // function enable two
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      fen2_q <= `PMT_RST_FUNC_EN2;
    end
    else if (wr_fen2)
    begin
      fen2_q <= i_wdata;
    end
  end

  // high-z override
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      hiz_q <= `PMT_RST_HIZ;
    end
    else if (wr_hiz)
    begin
      hiz_q <= wmerge(hiz_q, i_wdata, `PMT_HIZ_WMASK);
    end
  end

  // function clock gate
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      gate_q <= `PMT_RST_GATE;
    end
    else if (wr_gate)
    begin
      gate_q <= wmerge(gate_q, i_wdata, `PMT_GATE_WMASK);
    end
  end

  // clock source, inverted strap loaded into bit 0 after reset
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      src_q <= `PMT_RST_CLKSRC;
      strap_wait_q <= 2'h0;
    end
    else
    begin
      if (wr_clksrc)
      begin
        src_q <= i_wdata[2:0];
      end
      else if (strap_load)
      begin
        src_q[0] <= ~strap_s_q[1];
      end
      if (strap_wait_q != `PMT_STRAP_DONE)
      begin
        strap_wait_q <= strap_wait_q + 2'h1;
      end
    end
  end

  // trigger enables
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      trig_q <= `PMT_RST_TRIG;
    end
    else if (tmr_init)
    begin
      trig_q <= `PMT_RST_TRIG;
    end
    else if (wr_trig)
    begin
      trig_q <= wmerge(trig_q, i_wdata, `PMT_TRIG_WMASK);
    end
  end

  // programmed period
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      period_q <= `PMT_RST_PERIOD;
    end
    else if (tmr_init)
    begin
      period_q <= `PMT_RST_PERIOD;
    end
    else if (wr_period)
    begin
      period_q <= i_wdata;
    end
  end

  // pm function active
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pm_act_q <= 1'b0;
    end
    else if (i_sw_rst)
    begin
      pm_act_q <= 1'b0;
    end
    else if (i_pm_activate)
    begin
      pm_act_q <= 1'b1;
    end
  end

  // countdown state machine
  always_comb
  begin
    st_d = st_q;
    cnt_d = cnt_q;
    pre_d = tick ? '0 : pre_q + PW'(1);
    out_n_d = out_n_q;
    unique case (st_q)
      pmt_pkg::PMT_ST_IDLE: ;
      pmt_pkg::PMT_ST_RUN:
      begin
        if (reload)
        begin
          cnt_d = period_q;
          pre_d = '0;
        end
        else if (tick)
        begin
          cnt_d = cnt_q - 8'h01;
          if (cnt_q == 8'h01)
          begin
            st_d = pmt_pkg::PMT_ST_FIRED;
            out_n_d = 1'b0;
          end
        end
      end
      pmt_pkg::PMT_ST_FIRED: ;
      default: st_d = pmt_pkg::PMT_ST_IDLE;
    endcase
    if (st_d != pmt_pkg::PMT_ST_RUN)
    begin
      pre_d = '0;
    end
    if (wr_period)
    begin
      cnt_d = i_wdata;
      pre_d = '0;
      out_n_d = 1'b1;
      st_d = (i_wdata == 8'h00) ? pmt_pkg::PMT_ST_IDLE : pmt_pkg::PMT_ST_RUN;
    end
    if (tmr_init)
    begin
      cnt_d = 8'h00;
      pre_d = '0;
      out_n_d = 1'b1;
      st_d = pmt_pkg::PMT_ST_IDLE;
    end
  end

  // state and output
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= pmt_pkg::PMT_ST_IDLE;
      out_n_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      out_n_q <= out_n_d;
    end
  end

  // count and minute prescaler
  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      cnt_q <= 8'h00;
      pre_q <= '0;
    end
    else
    begin
      cnt_q <= cnt_d;
      pre_q <= pre_d;
    end
  end

  // read mux
  wire [7:0] clksrc_rd = (8'(src_q) & `PMT_CLKSRC_WMASK) | (8'(mul_s_q[1]) << `PMT_BIT_MUL_OK);
  wire [7:0] gate_rd = (gate_q & `PMT_GATE_WMASK) | (8'(b1_s_q[1]) << `PMT_BIT_BUSY1)
    | (8'(b2_s_q[1]) << `PMT_BIT_BUSY2);
  wire [7:0] stat_rd = 8'(out_n_q) << `PMT_BIT_OUT_ST;
  wire [7:0] idx_rd = {3'h0, idx_q};
  logic [7:0] dat_rd;
  always_comb
  begin
    unique case (idx_q)
      `PMT_IDX_FUNC_EN2: dat_rd = fen2_q;
      `PMT_IDX_HIZ: dat_rd = hiz_q;
      `PMT_IDX_CLKSRC: dat_rd = clksrc_rd;
      `PMT_IDX_GATE: dat_rd = gate_rd;
      `PMT_IDX_PERIOD: dat_rd = period_q;
      `PMT_IDX_TRIG: dat_rd = trig_q;
      `PMT_IDX_STATUS: dat_rd = stat_rd;
      default: dat_rd = 8'h00;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_q <= 8'h00;
    end
    else if (i_rd)
    begin
      rdata_q <= i_addr ? dat_rd : idx_rd;
    end
  end

  assign o_rdata = rdata_q;
  // override or own config bit puts a function in high-z
  assign o_hiz.kbd = hiz_q[`PMT_BIT_HIZ_KBD] | i_cfg_hiz.kbd;
  assign o_hiz.fdc = hiz_q[`PMT_BIT_HIZ_FDC] | i_cfg_hiz.fdc;
  assign o_hiz.par = hiz_q[`PMT_BIT_HIZ_PAR] | i_cfg_hiz.par;
  assign o_hiz.uart2 = hiz_q[`PMT_BIT_HIZ_UART2] | i_cfg_hiz.uart2;
  assign o_hiz.uart1 = hiz_q[`PMT_BIT_HIZ_UART1] | i_cfg_hiz.uart1;
  // clock runs only with gate bit and own config bit both set
  assign o_par_clk_en = gate_q[`PMT_BIT_CLK_PAR] & i_cfg_clk.par;
  assign o_uart2_clk_en = gate_q[`PMT_BIT_CLK_UART2] & i_cfg_clk.uart2;
  assign o_uart1_clk_en = gate_q[`PMT_BIT_CLK_UART1] & i_cfg_clk.uart1;
  assign o_clk_src = src_q[1:0];
  assign o_mul_en = src_q[`PMT_BIT_MUL_EN];
  assign o_gpio_en = fen2_q[`PMT_BIT_GPIO_EN];
  assign o_pm_timer_en = gate_q[`PMT_BIT_TMR_CLK];
  assign o_pm_active = pm_act_q;
  assign o_timeout_out_n = out_n_q;
endmodule

// [core/pmt_regs.svh]
// pmt_regs.svh: register indexes, reset values, field positions and timing constants of the pm control group
// assumes inclusion by bare name from the design module
// Operation
// - gpio enable bit low disables gpio ports, ignores access and activate bit
// - function signals go high-z when override bit or own config bit 0 set
// - hard reset clears the high-z override register to 00h
// - override bits: 0 kbd/mouse, 3 floppy, 4 parallel, 5 uart2/ir, 6 uart1
// - clock source field: 00 ext 24 MHz, 10 ext 48 MHz, 11 multiplier, 01 reserved
// - reset loads clock source bit 0 with inverted clock strap
// - multiplier runs only while its enable bit is 1; default 0
// - read-only status bit 7 shows multiplier output stable and toggling
// - hard reset sets function clock gate register to 0Eh
// - pm timer clock enable 0 blocks timer registers; status/enable flags read 0; here the bit only drives o_pm_timer_en, timer registers stay accessible
// - parallel, uart2, uart1 clocks run when gate bit and own config bit 1 set
// - read-only busy bits: bit 6 uart2, bit 7 uart1
// - period register holds programmed value 1..255 minutes, never the live count
// - writing zero to period stops the countdown and deasserts output
// - hard reset or pm activation clears period and disables timer and output
// - software reset deactivates pm function and resets the timer
// - countdown reaching zero asserts active-low timeout output
// - writing non-zero period returns timeout output high
// - each enabled trigger reloads counter from programmed period
// - triggers come from active irq state, regardless of polarity or type
// - reset and pm activation clear all trigger enable bits
// - trigger bits: 0 keyboard controller irq, 1 mouse irq, 2 uart1 irq
// - trigger bit 3 admits uart2 irq; bits 7 to 4 reserved
// - read-only status bit shows timeout output level, 0 active
`ifndef PMT_REGS_SVH
`define PMT_REGS_SVH
`define PMT_IDX_FUNC_EN2 5'h01
`define PMT_IDX_HIZ 5'h02
`define PMT_IDX_CLKSRC 5'h03
`define PMT_IDX_GATE 5'h04
`define PMT_IDX_PERIOD 5'h05
`define PMT_IDX_TRIG 5'h06
`define PMT_IDX_STATUS 5'h07
`define PMT_RST_FUNC_EN2 8'h87
`define PMT_RST_HIZ 8'h00
`define PMT_RST_GATE 8'h0E
`define PMT_RST_PERIOD 8'h00
`define PMT_RST_TRIG 8'h00
`define PMT_HIZ_WMASK 8'h79
`define PMT_CLKSRC_WMASK 8'h07
`define PMT_GATE_WMASK 8'h0F
`define PMT_TRIG_WMASK 8'h0F
`define PMT_IDX_WMASK 8'h1F
`define PMT_BIT_GPIO_EN 7
`define PMT_BIT_MUL_EN 2
`define PMT_BIT_MUL_OK 7
`define PMT_BIT_TMR_CLK 0
`define PMT_BIT_BUSY2 6
`define PMT_BIT_BUSY1 7
`define PMT_MINUTE_S 60
`define PMT_RST_IDX 5'h00
`define PMT_RST_CLKSRC 3'h0
`define PMT_STRAP_SETTLE 2'h2
`define PMT_STRAP_DONE 2'h3
`define PMT_BIT_HIZ_KBD 0
`define PMT_BIT_HIZ_FDC 3
`define PMT_BIT_HIZ_PAR 4
`define PMT_BIT_HIZ_UART2 5
`define PMT_BIT_HIZ_UART1 6
`define PMT_BIT_CLK_PAR 1
`define PMT_BIT_CLK_UART2 2
`define PMT_BIT_CLK_UART1 3
`define PMT_BIT_OUT_ST 0
`endif

// [core/pmt_pkg.sv]
// pmt_pkg.sv: types shared by the pm control block
// assumes pmt_regs.svh on the include path
package pmt_pkg;
  // per-function signal group: kbd/mouse, floppy, parallel, uart2, uart1
  typedef struct packed {
    logic uart1;
    logic uart2;
    logic par;
    logic fdc;
    logic kbd;
  } pmt_func_s;
  // clock source codes
  typedef enum logic [1:0] {
    PMT_SRC_X24 = 2'h0,
    PMT_SRC_RSV = 2'h1,
    PMT_SRC_X48 = 2'h2,
    PMT_SRC_MUL = 2'h3
  } pmt_src_e;
  typedef enum logic [2:0] {
    PMT_ST_IDLE = 3'h1,
    PMT_ST_RUN = 3'h2,
    PMT_ST_FIRED = 3'h4
  } pmt_state_e;
endpackage

// [testbench/pmt_ctrl_chk.sv]
// pmt_ctrl_chk.sv: port assertions for pmt_ctrl
// assumes bind onto pmt_ctrl with MINUTE_CYCLES handed on
`timescale 1ns/100ps
module pmt_ctrl_chk #(
  parameter int unsigned MINUTE_CYCLES = 4
) (
  input wire logic i_ref_clk, // clk
  input wire logic i_rst, // rst
  input wire logic i_sw_rst, // sw rst
  input wire logic i_pm_activate, // act
  input wire logic i_addr, // port
  input wire logic i_wr, // wr
  input wire logic i_rd, // rd
  input wire logic [7:0] i_wdata, // data
  input wire logic [7:0] o_rdata, // rdata
  input wire pmt_pkg::pmt_func_s i_cfg_hiz, // own cfg bit 0
  input wire pmt_pkg::pmt_func_s i_cfg_clk, // cfg1
  input wire pmt_pkg::pmt_func_s o_hiz, // hiz
  input wire logic o_par_clk_en, // par clk
  input wire logic o_pm_active, // active
  input wire logic o_timeout_out_n // out
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [4:0] idx_q;
  logic [15:0] quiet_q;
  wire logic per_wr = i_wr && i_addr && idx_q == 5'h05;
  // index as the host last set it
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst) idx_q <= 5'h00;
    else if (i_wr && !i_addr) idx_q <= i_wdata[4:0];
  // cycles since the last period write, software reset or pm activation; trigger reloads do not clear it
  always_ff @(posedge i_ref_clk or posedge i_rst)
    if (i_rst) quiet_q <= 16'h0000;
    else if (per_wr || i_sw_rst || i_pm_activate) quiet_q <= 16'h0000;
    else if (quiet_q != 16'hFFFF) quiet_q <= quiet_q + 16'h0001;
  hiz_or_cfg_a: assert property ((o_hiz | ~i_cfg_hiz) == 5'h1F) else $error("hiz lost");
  par_clk_and_a: assert property (o_par_clk_en |-> i_cfg_clk.par) else $error("par clk");
  zero_write_a: assert property (per_wr && i_wdata == 8'h00 |=> o_timeout_out_n) else $error("zero");
  nonzero_write_a: assert property (per_wr && i_wdata != 8'h00 |=> o_timeout_out_n) else $error("nz");
  sw_reset_a: assert property (i_sw_rst |=> o_timeout_out_n && !o_pm_active) else $error("sw");
  pm_activate_a: assert property (i_pm_activate && !i_sw_rst |=> o_timeout_out_n && o_pm_active)
    else $error("act");
  fire_delay_a: assert property ($fell(o_timeout_out_n) |-> {16'h0000, quiet_q} >= MINUTE_CYCLES)
    else $error("early");
  rdata_hold_a: assert property (!i_rd |=> $stable(o_rdata)) else $error("rdata");
endmodule
bind pmt_ctrl pmt_ctrl_chk #(.MINUTE_CYCLES(MINUTE_CYCLES)) chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_sw_rst(i_sw_rst), .i_pm_activate(i_pm_activate), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd),
  .i_wdata(i_wdata), .o_rdata(o_rdata), .i_cfg_hiz(i_cfg_hiz), .i_cfg_clk(i_cfg_clk), .o_hiz(o_hiz),
  .o_par_clk_en(o_par_clk_en), .o_pm_active(o_pm_active), .o_timeout_out_n(o_timeout_out_n));

// [testbench/pmt_ctrl_test.sv]
// pmt_ctrl_test.sv: self-checking bench for pmt_ctrl
// assumes pmt_pkg and the checker compiled first
`timescale 1ns/100ps
module pmt_ctrl_test;
  logic i_ref_clk = 1'b0, i_rst = 1'b1, i_sw_rst = 1'b0, i_pm_activate = 1'b0;
  logic i_addr = 1'b0, i_wr = 1'b0, i_rd = 1'b0, rd_d = 1'b0;
  logic [7:0] i_wdata = 8'h00, exp_v, o_rdata;
  logic [3:0] i_irq = 4'h0;
  logic strap = 1'b0, mul_ok = 1'b1, busy2 = 1'b0, busy1 = 1'b1;
  pmt_pkg::pmt_func_s i_cfg_hiz = 5'h00, i_cfg_clk = 5'h15, o_hiz;
  logic [1:0] o_clk_src;
  logic o_par, o_u2, o_u1, o_mul_en, o_gpio_en, o_pmt_en, o_pm_active, o_out_n;
  logic [31:0] seed = 32'h5F205891;
  logic [15:0] rv[8] = '{16'h0187, 16'h0200, 16'h0381, 16'h048E, 16'h0500, 16'h0600, 16'h0701, 16'h0800};
  int err_count = 0, tests_run = 0;
  logic [7:0] exp_q[$];
  pmt_ctrl #(.MINUTE_CYCLES(4)) DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sw_rst(i_sw_rst),
    .i_pm_activate(i_pm_activate), .i_addr(i_addr), .i_wr(i_wr), .i_rd(i_rd), .i_wdata(i_wdata),
    .o_rdata(o_rdata), .i_clk_strap_pin(strap), .i_mul_stable(mul_ok), .i_uart2_busy(busy2),
    .i_uart1_busy(busy1), .i_cfg_hiz(i_cfg_hiz), .i_cfg_clk(i_cfg_clk), .i_irq_active(i_irq),
    .o_hiz(o_hiz), .o_par_clk_en(o_par), .o_uart2_clk_en(o_u2), .o_uart1_clk_en(o_u1),
    .o_clk_src(o_clk_src), .o_mul_en(o_mul_en), .o_gpio_en(o_gpio_en), .o_pm_timer_en(o_pmt_en),
    .o_pm_active(o_pm_active), .o_timeout_out_n(o_out_n));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask
  task automatic reg_wr(input logic [7:0] idx, input logic [7:0] d);
    wr(1'b0, idx);
    wr(1'b1, d);
  endtask
  task automatic reg_rd(input logic [7:0] idx, input logic [7:0] e);
    wr(1'b0, idx);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    @(negedge i_ref_clk);
  endtask
  // read data lands one cycle after the read strobe
  always @(posedge i_ref_clk) rd_d <= i_rd;
  always @(negedge i_ref_clk)
    if (rd_d)
      chk(o_rdata, exp_q.pop_front());
  initial
  begin
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #(25 * 8000);
    err_count++;
    end_sim();
  end
  initial
  begin
    repeat (10) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    cyc(3);
    foreach (rv[k])
      reg_rd(rv[k][15:8], rv[k][7:0]);
    repeat (6)
    begin
      seed = xs(seed);
      exp_v = seed[7:0] & 8'h79;
      reg_wr(8'h02, seed[7:0]);
      i_cfg_hiz <= seed[12:8];
      reg_rd(8'h02, exp_v);
      cyc(0);
      chk({3'h0, o_hiz}, {3'h0, {exp_v[6:3], exp_v[0]} | seed[12:8]});
    end
    for (int s = 0; s < 4; s++)
    begin
      reg_wr(8'h03, 8'h04 | s[7:0]);
      cyc(0);
      chk({5'h00, o_mul_en, o_clk_src}, 8'h04 | s[7:0]);
    end
    reg_wr(8'h03, 8'hFB);
    reg_rd(8'h03, 8'h83);
    reg_wr(8'h04, 8'h0F);
    cyc(0);
    chk({4'h0, o_pmt_en, o_par, o_u2, o_u1}, 8'h0D);
    reg_wr(8'h04, 8'h00);
    reg_wr(8'h01, 8'h07);
    cyc(0);
    chk({3'h0, o_gpio_en, o_pmt_en, o_par, o_u2, o_u1}, 8'h00);
    reg_wr(8'h05, 8'h02);
    cyc(5);
    chk({7'h00, o_out_n}, 8'h01);
    cyc(6);
    reg_rd(8'h07, 8'h00);
    reg_rd(8'h05, 8'h02);
    reg_wr(8'h05, 8'h01);
    cyc(0);
    chk({7'h00, o_out_n}, 8'h01);
    for (int b = 0; b < 4; b++)
    begin
      reg_wr(8'h06, 8'h01 << b);
      reg_wr(8'h05, 8'h02);
      repeat (6)
      begin
        @(posedge i_ref_clk);
        i_irq <= 4'h1 << b;
        @(posedge i_ref_clk);
        i_irq <= 4'h0;
        repeat (2) @(posedge i_ref_clk);
      end
      cyc(0);
      chk({7'h00, o_out_n}, 8'h01);
    end
    reg_wr(8'h06, 8'hFF);
    reg_rd(8'h06, 8'h0F);
    cyc(2);
    chk({7'h00, o_out_n}, 8'h00);
    reg_wr(8'h05, 8'h00);
    cyc(12);
    chk({7'h00, o_out_n}, 8'h01);
    reg_wr(8'h05, 8'h01);
    repeat (8) @(posedge i_ref_clk);
    i_pm_activate <= 1'b1;
    @(posedge i_ref_clk);
    i_pm_activate <= 1'b0;
    cyc(1);
    chk({6'h00, o_pm_active, o_out_n}, 8'h03);
    reg_rd(8'h05, 8'h00);
    reg_rd(8'h06, 8'h00);
    reg_wr(8'h05, 8'h01);
    reg_wr(8'h06, 8'h05);
    i_sw_rst <= 1'b1;
    @(posedge i_ref_clk);
    i_sw_rst <= 1'b0;
    cyc(1);
    chk({6'h00, o_pm_active, o_out_n}, 8'h01);
    reg_rd(8'h05, 8'h00);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    strap <= 1'b1;
    mul_ok <= 1'b0;
    busy2 <= 1'b1;
    busy1 <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    reg_rd(8'h03, 8'h00);
    reg_rd(8'h04, 8'h4E);
    cyc(3);
    end_sim();
  end
endmodule
